/* rfsh_regs.vh */
`ifndef RFSH_REGS_VH
`define RFSH_REGS_VH

// ****************************************************************
// apb register map (byte addresses, one word each)
// ****************************************************************
`define RFSH_OFS_CTRL        8'h00
`define RFSH_OFS_ADDR        8'h04
`define RFSH_OFS_WDATA       8'h08
`define RFSH_OFS_RDATA       8'h0C
`define RFSH_OFS_STATUS      8'h10

// control word fields
`define RFSH_CTRL_START      0
`define RFSH_CTRL_FIFO       1
`define RFSH_CTRL_READ       2

// status word fields
`define RFSH_STAT_BUSY       0
`define RFSH_STAT_DONE       1

// reset values
`define RFSH_RST_ADDR        7'h00
`define RFSH_RST_WDATA       8'h00
`define RFSH_RST_RDATA       8'h00

// ****************************************************************
// frame shape
// ****************************************************************
`define RFSH_REG_BITS        5'h10
`define RFSH_FIFO_BITS       5'h08
`define RFSH_REG_RELEASE     5'h09

// ****************************************************************
// timing: figures in their own units, counts derived from pclk
// ****************************************************************
`define RFSH_PCLK_KHZ        25000
`define RFSH_SCLK_MAX_KHZ    5000
`define RFSH_FIFO_HOLD_NS    2000
`define RFSH_FIFO_GAP_NS     4000
// least times round up to whole pclk cycles
`define RFSH_HALF_CYC   ((`RFSH_PCLK_KHZ + 2 * `RFSH_SCLK_MAX_KHZ - 1) / (2 * `RFSH_SCLK_MAX_KHZ))
`define RFSH_HOLD_CYC   ((`RFSH_FIFO_HOLD_NS * (`RFSH_PCLK_KHZ / 1000) + 999) / 1000)
`define RFSH_GAP_CYC    ((`RFSH_FIFO_GAP_NS * (`RFSH_PCLK_KHZ / 1000) + 999) / 1000)

`endif

/* rfsh_sync2.v */
`timescale 1ns/10ps
// ****************************************************************
// two-flop synchroniser for one pin level
// ****************************************************************
module rfsh_sync2 (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // level in and out
    input  wire d_in,
    output wire d_sync
);

    reg meta_q;
    reg sync_q;

    // first flop is read only by the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign d_sync = sync_q;

endmodule // rfsh_sync2

/* rfsh_timer.v */
`timescale 1ns/10ps
// ****************************************************************
// loadable down counter timing every phase of a frame
// ****************************************************************
module rfsh_timer (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // load a fresh count of cycles
    input  wire       load,
    input  wire [7:0] load_val,
    // current count and end of phase
    output wire [7:0] count,
    output wire       expired
);

    reg [7:0] cnt_q;
    reg [7:0] cnt_d;

    // count holds at zero once run out
    always @* begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = load_val;
        else if (cnt_q != 8'h00)
            cnt_d = cnt_q - 8'h01;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_d;
    end

    // a phase loaded with n lasts exactly n cycles
    assign count   = cnt_q;
    assign expired = (cnt_q <= 8'h01);

endmodule // rfsh_timer

/* rfsh_host.v */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "rfsh_regs.vh"
// ****************************************************************
// serial host for the radio register and buffer port
// ****************************************************************
module rfsh_host (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // serial link to the radio
    output wire        sclk,
    output wire        reg_select_n,
    output wire        fifo_select_n,
    input  wire        sdio_i,
    output wire        sdio_o,
    output wire        sdio_oe
);

    // ****************************************************************
    // phase lengths in pclk cycles
    // ****************************************************************
    // integer forms first, then cut to the timer width on purpose
    localparam integer HALF_INT = `RFSH_HALF_CYC;
    localparam integer FULL_INT = 2 * `RFSH_HALF_CYC;
    localparam integer HOLD_INT = `RFSH_HOLD_CYC;
    localparam integer GAP_INT  = `RFSH_GAP_CYC;
    // limitation: a count above 255 would need a wider timer
    localparam [7:0]   HALF_CYC = HALF_INT[7:0];
    localparam [7:0]   FULL_CYC = FULL_INT[7:0];
    localparam [7:0]   HOLD_CYC = HOLD_INT[7:0];
    localparam [7:0]   GAP_CYC  = GAP_INT[7:0];

    // frame states
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_LEAD = 3'h1;
    localparam [2:0] S_LOW  = 3'h2;
    localparam [2:0] S_HIGH = 3'h3;
    localparam [2:0] S_TAIL = 3'h4;
    localparam [2:0] S_GAP  = 3'h5;

    // ****************************************************************
    // declarations
    // ****************************************************************
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [6:0]  addr_q;
    reg  [7:0]  wdata_q;
    reg  [7:0]  rdata_q;
    reg  [7:0]  rdata_d;
    reg         done_q;
    reg         done_d;
    reg         kind_fifo_q;
    reg         kind_fifo_d;
    reg         dir_read_q;
    reg         dir_read_d;
    reg  [15:0] shift_q;
    reg  [15:0] shift_d;
    reg  [4:0]  bits_q;
    reg  [4:0]  bits_d;
    reg         sclk_q;
    reg         sclk_d;
    reg         rsel_n_q;
    reg         rsel_n_d;
    reg         fsel_n_q;
    reg         fsel_n_d;
    reg         oe_q;
    reg         oe_d;
    reg  [31:0] prdata_q;
    reg  [31:0] prdata_d;
    reg         tmr_load;
    reg  [7:0]  tmr_val;
    wire [7:0]  tmr_count;
    wire        tmr_expired;
    wire        sdio_s;
    wire        apb_setup;
    wire        apb_wr;
    wire        mapped;
    wire        start_req;
    wire        frame_end;

    // ****************************************************************
    // submodules
    // ****************************************************************
    // pin input crosses into pclk before anything reads it
    rfsh_sync2 u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_in    (sdio_i),
        .d_sync  (sdio_s)
    );

    // one timer serves every phase, so phases never overlap
    rfsh_timer u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .count    (tmr_count),
        .expired  (tmr_expired)
    );

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // zero wait states: read data is latched in the setup cycle, writes in the access cycle
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign mapped    = (paddr == `RFSH_OFS_CTRL)  | (paddr == `RFSH_OFS_ADDR) |
                       (paddr == `RFSH_OFS_WDATA) | (paddr == `RFSH_OFS_RDATA) |
                       (paddr == `RFSH_OFS_STATUS);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = prdata_q;

    // a start while busy is dropped; busy shows it in status
    // frames only on software order
    assign start_req = apb_wr & (paddr == `RFSH_OFS_CTRL) &
                       pwdata[`RFSH_CTRL_START] & (state_q == S_IDLE);
    assign frame_end = (state_q == S_GAP) & tmr_expired;

    // status is caught at setup, so a poll may lag by a cycle
    // read data mux, registered for the access cycle
    always @* begin
        prdata_d = prdata_q;
        if (apb_setup) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                `RFSH_OFS_CTRL: begin
                    prdata_d[`RFSH_CTRL_FIFO] = kind_fifo_q;
                    prdata_d[`RFSH_CTRL_READ] = dir_read_q;
                end
                `RFSH_OFS_ADDR:  prdata_d[6:0] = addr_q;
                `RFSH_OFS_WDATA: prdata_d[7:0] = wdata_q;
                `RFSH_OFS_RDATA: prdata_d[7:0] = rdata_q;
                `RFSH_OFS_STATUS: begin
                    prdata_d[`RFSH_STAT_BUSY] = (state_q != S_IDLE);
                    prdata_d[`RFSH_STAT_DONE] = done_q;
                end
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // address and write byte registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q  <= `RFSH_RST_ADDR;
            wdata_q <= `RFSH_RST_WDATA;
        end else if (apb_wr) begin
            if (paddr == `RFSH_OFS_ADDR)
                addr_q <= pwdata[6:0];
            if (paddr == `RFSH_OFS_WDATA)
                wdata_q <= pwdata[7:0];
        end
    end

    // done is sticky; a frame ending in the clearing cycle wins
    always @* begin
        done_d = done_q;
        if (apb_wr && (paddr == `RFSH_OFS_STATUS) && pwdata[`RFSH_STAT_DONE])
            done_d = 1'b0;
        if (start_req)
            done_d = 1'b0;
        if (frame_end)
            done_d = 1'b1;
    end

    // ****************************************************************
    // frame sequencer
    // ****************************************************************
    always @* begin
        state_d     = state_q;
        kind_fifo_d = kind_fifo_q;
        dir_read_d  = dir_read_q;
        shift_d     = shift_q;
        bits_d      = bits_q;
        sclk_d      = sclk_q;
        rsel_n_d    = rsel_n_q;
        fsel_n_d    = fsel_n_q;
        oe_d        = oe_q;
        rdata_d     = rdata_q;
        tmr_load    = 1'b0;
        tmr_val     = HALF_CYC;
        case (state_q)
            S_IDLE: begin
                // clock rests low between frames
                sclk_d = 1'b0;
                if (start_req) begin
                    kind_fifo_d = pwdata[`RFSH_CTRL_FIFO];
                    dir_read_d  = pwdata[`RFSH_CTRL_READ];
                    tmr_load    = 1'b1;
                    state_d     = S_LEAD;
                    if (pwdata[`RFSH_CTRL_FIFO]) begin
                        // only one select at a time
                        fsel_n_d = 1'b0;
                        shift_d  = {wdata_q, 8'h00};
                        bits_d   = `RFSH_FIFO_BITS;
                        oe_d     = ~pwdata[`RFSH_CTRL_READ];
                        tmr_val  = FULL_CYC;
                    end else begin
                        rsel_n_d = 1'b0;
                        shift_d  = {pwdata[`RFSH_CTRL_READ], addr_q, wdata_q};
                        bits_d   = `RFSH_REG_BITS;
                        oe_d     = 1'b0;
                        tmr_val  = HALF_CYC;
                    end
                end
            end
            S_LEAD: begin
                if (tmr_expired) begin
                    tmr_load = 1'b1;
                    tmr_val  = HALF_CYC;
                    if (kind_fifo_q) begin
                        // buffer frames open on a rise, no low phase first
                        sclk_d  = 1'b1;
                        state_d = S_HIGH;
                    end else begin
                        oe_d    = 1'b1;
                        state_d = S_LOW;
                    end
                end
            end
            S_LOW: begin
                if (tmr_expired) begin
                    sclk_d   = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val  = HALF_CYC;
                    state_d  = S_HIGH;
                end
            end
            S_HIGH: begin
                // let go one cycle before the fall
                if (!kind_fifo_q && dir_read_q && (bits_q == `RFSH_REG_RELEASE) &&
                    (tmr_count == 8'h02))
                    oe_d = 1'b0;
                if (tmr_expired) begin
                    sclk_d   = 1'b0;
                    shift_d  = {shift_q[14:0], sdio_s};
                    bits_d   = bits_q - 5'h01;
                    tmr_load = 1'b1;
                    if (bits_q == 5'h01) begin
                        rdata_d = {shift_q[6:0], sdio_s};
                        oe_d    = 1'b0;
                        state_d = S_TAIL;
                        tmr_val = kind_fifo_q ? HOLD_CYC : HALF_CYC;
                    end else begin
                        // more bits to go: back to a low phase
                        tmr_val = HALF_CYC;
                        state_d = S_LOW;
                    end
                end
            end
            S_TAIL: begin
                // only one select was low, so raising both is safe
                if (tmr_expired) begin
                    rsel_n_d = 1'b1;
                    fsel_n_d = 1'b1;
                    tmr_load = 1'b1;
                    // 4 us high between buffer accesses
                    tmr_val  = kind_fifo_q ? GAP_CYC : HALF_CYC;
                    state_d  = S_GAP;
                end
            end
            S_GAP: begin
                // gap over: busy drops and done rises
                if (tmr_expired)
                    state_d = S_IDLE;
            end
            default: begin
                rsel_n_d = 1'b1;
                fsel_n_d = 1'b1;
                oe_d     = 1'b0;
                sclk_d   = 1'b0;
                state_d  = S_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // state and pin flops
    // ****************************************************************
    // reset leaves the link idle: clock low, selects high
    // half period count keeps sclk under its ceiling
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= S_IDLE;
            kind_fifo_q <= 1'b0;
            dir_read_q  <= 1'b0;
            shift_q     <= 16'h0000;
            bits_q      <= 5'h00;
            sclk_q      <= 1'b0;
            rsel_n_q    <= 1'b1;
            fsel_n_q    <= 1'b1;
            oe_q        <= 1'b0;
            rdata_q     <= `RFSH_RST_RDATA;
            done_q      <= 1'b0;
            prdata_q    <= 32'h0000_0000;
        end else begin
            state_q     <= state_d;
            kind_fifo_q <= kind_fifo_d;
            dir_read_q  <= dir_read_d;
            shift_q     <= shift_d;
            bits_q      <= bits_d;
            sclk_q      <= sclk_d;
            rsel_n_q    <= rsel_n_d;
            fsel_n_q    <= fsel_n_d;
            oe_q        <= oe_d;
            rdata_q     <= rdata_d;
            done_q      <= done_d;
            prdata_q    <= prdata_d;
        end
    end

    // pins straight from flops, no glitches on the link
    assign sclk          = sclk_q;
    assign reg_select_n  = rsel_n_q;
    assign fifo_select_n = fsel_n_q;
    // sdio_o always shows the top bit; oe decides who owns the line
    assign sdio_o        = shift_q[15];
    assign sdio_oe       = oe_q;

endmodule // rfsh_host

/* rfsh_host_props.sv */
`timescale 1ns/10ps
`include "rfsh_regs.vh"
// ****************************************
// link timing checker on the host pins
// ****************************************
module rfsh_host_props (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // serial link
    input wire sclk,
    input wire reg_select_n,
    input wire fifo_select_n,
    input wire sdio_o,
    input wire sdio_oe
);
    logic       sclk_q;
    logic [4:0] rise_q;
    logic [7:0] low_q;
    logic [7:0] hi_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // rises per frame, cycles since last fall, cycles buffer select high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            rise_q <= 5'h00;
            low_q  <= 8'h00;
            hi_q   <= 8'hFF; // idle since reset counts as a long gap
        end else begin
            sclk_q <= sclk;
            rise_q <= (reg_select_n && fifo_select_n) ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};
            low_q  <= sclk ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
            hi_q   <= !fifo_select_n ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
        end
    end

    sequence s_reg_lead;
        (!sdio_oe && !sclk)[*3] ##1 (sdio_oe && !sclk);
    endsequence
    sequence s_buf_lead;
        !sclk[*6] ##1 sclk;
    endsequence

    a_sel_exclusive: assert property (reg_select_n || fifo_select_n)
        else $error("both selects low");
    a_high_phase: assert property ($rose(sclk) |-> sclk[*3])
        else $error("serial clock high phase too short");
    a_low_phase: assert property ($fell(sclk) |-> !sclk[*3])
        else $error("serial clock low phase too short");
    a_reg_lead: assert property ($fell(reg_select_n) |-> s_reg_lead)
        else $error("direction bit not half a period after select");
    a_reg_tail: assert property ($rose(reg_select_n) |-> low_q >= `RFSH_HALF_CYC)
        else $error("register select raised too soon");
    a_turn_around: assert property ($fell(sdio_oe) && !reg_select_n && rise_q < 5'h10
        |-> rise_q == 5'h08 && sclk)
        else $error("data line released at wrong place");
    a_data_change: assert property ($changed(sdio_o) && $past(sdio_oe) && sdio_oe |-> !sclk)
        else $error("data changed while clock high");
    a_reg_bits: assert property ($rose(reg_select_n) |-> rise_q == 5'h10)
        else $error("register frame not sixteen clocks");
    a_buf_bits: assert property ($rose(fifo_select_n) |-> rise_q == 5'h08)
        else $error("buffer frame not eight clocks");
    a_buf_lead: assert property ($fell(fifo_select_n) |-> s_buf_lead)
        else $error("buffer select lead too short");
    a_buf_setup: assert property ($rose(sclk) && !fifo_select_n && rise_q == 5'h00
        |-> $past(sdio_o, 3) == sdio_o && $past(sdio_oe, 3) == sdio_oe)
        else $error("first buffer bit not set up early");
    a_buf_hold: assert property ($rose(fifo_select_n) |-> low_q >= `RFSH_HOLD_CYC)
        else $error("buffer select hold too short");
    a_buf_gap: assert property ($fell(fifo_select_n) |-> hi_q >= `RFSH_GAP_CYC)
        else $error("buffer select gap too short");
endmodule // rfsh_host_props

bind rfsh_host rfsh_host_props u_props (.pclk, .presetn, .sclk, .reg_select_n,
    .fifo_select_n, .sdio_o, .sdio_oe);

/* rfsh_dev_model.sv */
`timescale 1ns/10ps
// ****************************************
// radio port model: registers and buffers
// ****************************************
module rfsh_dev_model #(
    parameter logic [6:0] CFG_ADDR = 7'h69 // config place, arbitrary
) (
    // serial link from the host
    input  wire  sclk,
    input  wire  reg_select_n,
    input  wire  fifo_select_n,
    input  wire  sdio,
    // data line driver
    output logic dev_oe,
    output logic dev_d
);
    logic [7:0]  regs [0:127];
    logic [7:0]  txq [$];
    logic [7:0]  rxq [$];
    logic [7:0]  txall [$];
    logic [15:0] sh;
    logic [7:0]  ob;
    int          n;
    int          cap;

    // power-up state
    initial begin
        dev_oe = 1'b0;
        dev_d = 1'b0;
        n = 0;
        sh = 16'h0000;
        foreach (regs[k]) regs[k] = 8'h00;
    end

    // two 32-byte buffers, or one of 64 when joined
    // separate queues: loading transmit never touches receive
    assign cap = regs[CFG_ADDR][2] ? 64 : 32;

    // deselect ends the frame and frees the line
    always @(posedge reg_select_n or posedge fifo_select_n) begin
        n = 0;
        dev_oe <= 1'b0;
    end

    // buffer read: first bit out as soon as selected
    always @(negedge fifo_select_n) if (regs[CFG_ADDR][3]) begin
        ob = rxq.size() ? rxq[0] : 8'h00;
        dev_oe <= 1'b1;
        dev_d <= ob[7];
    end

    // sample on rising, msb first, one byte per frame
    always @(posedge sclk) begin
        sh = {sh[14:0], sdio};
        n = n + 1;
        if (!fifo_select_n && n == 8) begin
            if (regs[CFG_ADDR][3]) begin
                if (rxq.size()) void'(rxq.pop_front());
            end else if (txq.size() < cap) begin
                txq.push_back(sh[7:0]);
                txall.push_back(sh[7:0]);
            end
        end
        if (!reg_select_n && n == 16 && !sh[15]) begin
            regs[sh[14:8]] = sh[7:0];
            // flush bits empty a buffer at once
            if (sh[14:8] == CFG_ADDR) begin
                if (sh[0]) begin
                    txq = {};
                    txall = {};
                end
                if (sh[1]) rxq = {};
                // send empties the queue, restore refills it as loaded
                if (sh[5]) txq = {};
                if (sh[4]) txq = txall;
            end
        end
    end

    // change on falling; drive only after the fall ending the address
    always @(negedge sclk) begin
        if ((!reg_select_n && n == 16) || (!fifo_select_n && n == 8)) dev_oe <= 1'b0;
        else if (!reg_select_n && n == 8 && sh[7]) begin
            ob = regs[sh[6:0]];
            dev_oe <= 1'b1;
            dev_d <= ob[7];
        end else if (dev_oe) begin
            ob = ob << 1;
            dev_d <= ob[7];
        end
    end
endmodule // rfsh_dev_model

/* rfsh_tb.sv */
`timescale 1ns/10ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, x); end end
// ****************************************
// bench for the radio port host
// ****************************************
module tb;
    localparam logic [6:0] CFG = 7'h69;
    logic        pclk, presetn, psel, penable, pwrite, e;
    logic        flip_q = 1'b0;
    logic [7:0]  paddr, d;
    logic [6:0]  a;
    logic [31:0] pwdata, r;
    wire  [31:0] prdata;
    wire         pready, pslverr, sclk, reg_select_n, fifo_select_n;
    wire         sdio_o, sdio_oe, dev_oe, dev_d, line;
    int          fails, check_count, i;
    logic [7:0]  expq [$];

    rfsh_host u_rfsh_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .sclk, .reg_select_n, .fifo_select_n, .sdio_i(line),
        .sdio_o, .sdio_oe);
    rfsh_dev_model #(.CFG_ADDR(CFG)) u_dev (.sclk, .reg_select_n, .fifo_select_n,
        .sdio(line), .dev_oe, .dev_d);

    // no pull on the line: released, it toggles so a stale value cannot pass
    assign line = sdio_oe ? sdio_o : (dev_oe ? dev_d : flip_q);

    // toggle source and contention watch
    always @(posedge pclk) begin
        flip_q <= ~flip_q;
        `CHK(sdio_oe & dev_oe, 1'b0)
    end

    // clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // one apb transfer; r and e hold what the access edge carried
    task apb(input logic [7:0] ad, input logic w, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= ad;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin fails++; report_and_stop(); end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one link frame, waiting for done under a bound
    task frame(input logic f, input logic rd, input logic [6:0] ad, input logic [7:0] wd);
        int k;
        apb(8'h04, 1'b1, {25'h0, ad});
        apb(8'h08, 1'b1, {24'h0, wd});
        apb(8'h00, 1'b1, {29'h0, rd, f, 1'b1});
        for (k = 0; k < 300; k++) begin
            apb(8'h10, 1'b0, 32'h0);
            if (r[1] === 1'b1) break;
        end
        if (k == 300) begin fails++; report_and_stop(); end
        apb(8'h10, 1'b1, 32'h2);
    endtask

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fails = 0;
        check_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'h16C6E4DD));
        // reset values, then the unmapped word
        for (i = 0; i < 6; i++) begin
            apb(8'(i * 4), 1'b0, 32'h0);
            `CHK(r, 32'h0)
            `CHK(e, 1'(i == 5))
        end
        $display("test reset done");
        // register writes read back, end addresses first
        for (i = 0; i < 10; i++) begin
            a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
            if (a == CFG) a = 7'h00;
            d = 8'($urandom);
            frame(1'b0, 1'b0, a, d);
            `CHK(u_dev.regs[a], d)
            frame(1'b0, 1'b1, a, 8'($urandom));
            apb(8'h0C, 1'b0, 32'h0);
            `CHK(r, {24'h0, d})
        end
        $display("test registers done");
        // fill the transmit buffer past its size, join, flush
        for (i = 0; i < 33; i++) begin
            d = 8'($urandom);
            if (i < 32) expq.push_back(d);
            frame(1'b1, 1'b0, 7'h00, d);
        end
        `CHK(u_dev.txq.size(), 32)
        `CHK(u_dev.txq[0], expq[0])
        `CHK(u_dev.txq[31], expq[31])
        frame(1'b0, 1'b0, CFG, 8'h04);
        frame(1'b1, 1'b0, 7'h00, 8'h5A);
        `CHK(u_dev.txq.size(), 33)
        frame(1'b0, 1'b0, CFG, 8'h05);
        `CHK(u_dev.txq.size(), 0)
        // send empties the queue; restore brings the loaded byte back
        frame(1'b1, 1'b0, 7'h00, 8'hA5);
        frame(1'b0, 1'b0, CFG, 8'h24);
        `CHK(u_dev.txq.size(), 0)
        frame(1'b0, 1'b0, CFG, 8'h14);
        `CHK(u_dev.txq.size(), 1)
        `CHK(u_dev.txq[0], 8'hA5)
        $display("test buffer write done");
        // receive buffer drained byte by byte, then flushed
        expq = {};
        for (i = 0; i < 4; i++) begin
            d = 8'($urandom);
            expq.push_back(d);
            u_dev.rxq.push_back(d);
        end
        // split buffers: loading transmit leaves receive alone
        frame(1'b0, 1'b0, CFG, 8'h01);
        frame(1'b1, 1'b0, 7'h00, 8'hC3);
        `CHK(u_dev.txq.size(), 1)
        `CHK(u_dev.rxq.size(), 4)
        frame(1'b0, 1'b0, CFG, 8'h08);
        for (i = 0; i < 4; i++) begin
            frame(1'b1, 1'b1, 7'h00, 8'h00);
            apb(8'h0C, 1'b0, 32'h0);
            `CHK(r, {24'h0, expq[i]})
        end
        `CHK(u_dev.rxq.size(), 0)
        u_dev.rxq.push_back(8'h3C);
        frame(1'b0, 1'b0, CFG, 8'h0A);
        `CHK(u_dev.rxq.size(), 0)
        $display("test buffer read done");
        report_and_stop();
    end
endmodule // tb
